// >>> hw/dilc_top.sv
`include "dilc_regs.svh"
`default_nettype none
// ****************************************************************
// Sample FIFO.
// ****************************************************************
module dilc_fifo #(
	parameter int WIDTH = `DILC_DATA_WIDTH,
	parameter int DEPTH = `DILC_FIFO_DEPTH
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic [WIDTH-1:0] in_data_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	output logic [WIDTH-1:0] out_data_out,
	output logic out_valid_out,
	input wire logic out_ready_in
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	wire push = ce_in && in_valid_in && (count != (AW+1)'(DEPTH));
	wire pop = ce_in && out_ready_in && (count != '0);
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("FIFO depth must be a power of two of at least 2.");
	end
	assign in_ready_out = (count != (AW+1)'(DEPTH));
	assign out_valid_out = (count != '0);
	assign out_data_out = mem[rd_ptr];
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[wr_ptr] <= in_data_in;
		end
	end
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// ****************************************************************
	// FIFO assertions.
	// ****************************************************************
	property p_fifo_bound;
		@(posedge clk_in) disable iff (rst_in)
		count <= (AW+1)'(DEPTH);
	endproperty
	a_fifo_bound: assert property (p_fifo_bound) // see RULE2
		else $error("FIFO count above its depth.");

	property p_fifo_first;
		@(posedge clk_in) disable iff (rst_in)
		(push && count == '0) |=> out_valid_out
			&& out_data_out == $past(in_data_in);
	endproperty
	a_fifo_first: assert property (p_fifo_first) // see RULE2
		else $error("FIFO lost the word written into it while empty.");

	property p_fifo_freeze;
		@(posedge clk_in) disable iff (rst_in)
		!ce_in |=> $stable(count) && $stable(wr_ptr) && $stable(rd_ptr);
	endproperty
	a_fifo_freeze: assert property (p_fifo_freeze) // see RULE2
		else $error("FIFO state moved while the clock enable was low.");
endmodule : dilc_fifo

// ****************************************************************
// Input latch and reference/sleep control.
// ****************************************************************
module dilc_top #(
	parameter int WIDTH = `DILC_DATA_WIDTH,
	parameter int DEPTH = `DILC_FIFO_DEPTH
) (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic [WIDTH-1:0] sample_data_in,
	input wire logic sample_valid_in,
	output logic sample_ready_out,
	input wire logic sleep_request_in,
	input wire logic sleep_request_driven_in,
	input wire logic ref_select_in,
	output logic [WIDTH-1:0] code_out,
	output logic [WIDTH-1:0] code_comp_out,
	output logic standby_out,
	output logic bandgap_enable_out,
	output var dilc_pkg::dilc_ref_mode_t ref_mode_out,
	output logic reference_voltage_pin_is_input_out
);
	import dilc_pkg::*;
	logic [WIDTH-1:0] fifo_data;
	logic fifo_valid;
	logic fifo_ready;
	logic [WIDTH-1:0] master;
	if (WIDTH < 1 || WIDTH > `DILC_DATA_WIDTH) begin : g_bad_width
		$error("Data width not supported.");
	end
	dilc_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
		.clk_in(ref_clk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.in_data_in(sample_data_in),
		.in_valid_in(sample_valid_in),
		.in_ready_out(fifo_ready),
		.out_data_out(fifo_data),
		.out_valid_out(fifo_valid),
		.out_ready_in(1'b1)
	);
	wire sleep_level = sleep_request_driven_in & sleep_request_in; // see RULE6
	wire take_sample = ce_in && fifo_valid;
	wire [WIDTH-1:0] full_scale = WIDTH'(`DILC_FULL_SCALE);
	wire [WIDTH-1:0] next_comp = full_scale - master; // see RULE9
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			master <= WIDTH'(`DILC_SLAVE_RESET);
			sample_ready_out <= 1'b0;
		end else if (ce_in) begin
			sample_ready_out <= fifo_ready;
			if (take_sample) begin
				master <= fifo_data; // see RULE2 see RULE1
			end
		end
	end
	// Slave stage transfers on enabled falling edges and holds otherwise.
	always_ff @(negedge ref_clk_in) begin
		if (rst_in) begin
			code_out <= WIDTH'(`DILC_SLAVE_RESET);
			code_comp_out <= full_scale;
		end else if (ce_in) begin
			code_out <= master; // see RULE3 see RULE10
			code_comp_out <= next_comp; // see RULE9
		end
	end
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			standby_out <= 1'b0;
			bandgap_enable_out <= 1'b1;
			ref_mode_out <= DILC_REF_INTERNAL;
			reference_voltage_pin_is_input_out <= 1'b0;
		end else if (ce_in) begin
			standby_out <= sleep_level; // see RULE5
			bandgap_enable_out <= !ref_select_in; // see RULE7
			ref_mode_out <= ref_select_in ? DILC_REF_EXTERNAL
				: DILC_REF_INTERNAL; // see RULE8
			reference_voltage_pin_is_input_out <= ref_select_in; // see RULE8
		end
	end
	// ****************************************************************
	// Assertions.
	// ****************************************************************
	// A word leaves the FIFO and lands in the master latch.
	sequence s_capture;
		take_sample;
	endsequence

	// A cycle in which the master latch takes nothing.
	sequence s_no_capture;
		!take_sample;
	endsequence

	// A driven, high sleep request seen while enabled.
	sequence s_sleep_asked;
		ce_in && sleep_request_driven_in && sleep_request_in;
	endsequence

	// An enabled cycle with the sleep request pin left floating.
	sequence s_sleep_floating;
		ce_in && !sleep_request_driven_in;
	endsequence

	sequence s_internal_ref;
		ce_in && !ref_select_in;
	endsequence

	sequence s_external_ref;
		ce_in && ref_select_in;
	endsequence

	property p_master_capture;
		@(posedge ref_clk_in) disable iff (rst_in)
		s_capture |=> master == $past(fifo_data);
	endproperty
	a_master_capture: assert property (p_master_capture) // see RULE2
		else $error("Master latch missed a sample.");

	property p_master_hold;
		@(posedge ref_clk_in) disable iff (rst_in)
		s_no_capture |=> $stable(master);
	endproperty
	a_master_hold: assert property (p_master_hold) // see RULE2
		else $error("Master latch moved without a sample.");

	property p_slave_follows;
		@(negedge ref_clk_in) disable iff (rst_in)
		ce_in |=> code_out == $past(master);
	endproperty
	a_slave_follows: assert property (p_slave_follows) // see RULE3
		else $error("Output did not take master at falling edge.");

	property p_slave_freeze;
		@(negedge ref_clk_in) disable iff (rst_in)
		!ce_in |=> $stable(code_out) && $stable(code_comp_out);
	endproperty
	a_slave_freeze: assert property (p_slave_freeze) // see RULE10
		else $error("Output moved while the clock enable was low.");

	// Nothing moves the output from a rising edge to the next falling edge.
	property p_slave_hold;
		@(edge ref_clk_in) disable iff (rst_in)
		!ref_clk_in |=> $stable(code_out) && $stable(code_comp_out);
	endproperty
	a_slave_hold: assert property (p_slave_hold) // see RULE10
		else $error("Output changed between falling edges.");

	property p_slave_reset;
		@(negedge ref_clk_in)
		rst_in |=> code_out == WIDTH'(`DILC_SLAVE_RESET)
			&& code_comp_out == full_scale;
	endproperty
	a_slave_reset: assert property (p_slave_reset) // see RULE9
		else $error("Output stage not cleared by reset.");

	property p_complement;
		@(posedge ref_clk_in) disable iff (rst_in)
		(code_out + code_comp_out) == full_scale;
	endproperty
	a_complement: assert property (p_complement) // see RULE9
		else $error("Complement output does not sum to full scale.");

	property p_ready_freeze;
		@(posedge ref_clk_in) disable iff (rst_in)
		!ce_in |=> $stable(sample_ready_out);
	endproperty
	a_ready_freeze: assert property (p_ready_freeze) // see RULE2
		else $error("Ready moved while the clock enable was low.");

	property p_ctrl_reset;
		@(posedge ref_clk_in)
		rst_in |=> !standby_out && bandgap_enable_out
			&& ref_mode_out == DILC_REF_INTERNAL
			&& !reference_voltage_pin_is_input_out && !sample_ready_out;
	endproperty
	a_ctrl_reset: assert property (p_ctrl_reset) // see RULE6
		else $error("Controls not at their defaults after reset.");

	property p_standby;
		@(posedge ref_clk_in) disable iff (rst_in)
		ce_in |=> standby_out
			== $past(sleep_request_in && sleep_request_driven_in);
	endproperty
	a_standby: assert property (p_standby) // see RULE5
		else $error("Standby does not follow sleep request.");

	property p_standby_on;
		@(posedge ref_clk_in) disable iff (rst_in)
		s_sleep_asked |=> standby_out;
	endproperty
	a_standby_on: assert property (p_standby_on) // see RULE5
		else $error("Driven sleep request did not enter standby.");

	property p_standby_off;
		@(posedge ref_clk_in) disable iff (rst_in)
		(ce_in && !sleep_request_in) |=> !standby_out;
	endproperty
	a_standby_off: assert property (p_standby_off) // see RULE5
		else $error("Low sleep request did not select conversion.");

	property p_undriven;
		@(posedge ref_clk_in) disable iff (rst_in)
		s_sleep_floating |=> !standby_out;
	endproperty
	a_undriven: assert property (p_undriven) // see RULE6
		else $error("Undriven sleep request caused standby.");

	property p_ctrl_freeze;
		@(posedge ref_clk_in) disable iff (rst_in)
		!ce_in |=> $stable(standby_out) && $stable(bandgap_enable_out)
			&& $stable(ref_mode_out)
			&& $stable(reference_voltage_pin_is_input_out);
	endproperty
	a_ctrl_freeze: assert property (p_ctrl_freeze) // see RULE5
		else $error("Controls moved while the clock enable was low.");

	property p_ref_int;
		@(posedge ref_clk_in) disable iff (rst_in)
		s_internal_ref |=> bandgap_enable_out
			&& ref_mode_out == DILC_REF_INTERNAL
			&& !reference_voltage_pin_is_input_out;
	endproperty
	a_ref_int: assert property (p_ref_int) // see RULE7
		else $error("Internal reference not enabled.");

	property p_ref_ext;
		@(posedge ref_clk_in) disable iff (rst_in)
		s_external_ref |=> !bandgap_enable_out
			&& ref_mode_out == DILC_REF_EXTERNAL
			&& reference_voltage_pin_is_input_out;
	endproperty
	a_ref_ext: assert property (p_ref_ext) // see RULE8
		else $error("External reference not selected.");

	property p_ref_consistent;
		@(posedge ref_clk_in) disable iff (rst_in)
		bandgap_enable_out != reference_voltage_pin_is_input_out;
	endproperty
	a_ref_consistent: assert property (p_ref_consistent) // see RULE8
		else $error("Bandgap and reference pin direction disagree.");
endmodule : dilc_top
`default_nettype wire

// >>> hw/dilc_regs.svh
// Function
// RULE1: Sample word is unsigned binary, bit 0 least significant.
// RULE2: Capture the sample word into the master latch at each rising edge. Code loads it from the FIFO only on enabled edges with a word waiting.
// RULE3: Output takes the captured word only at the next falling edge.
// RULE4: Source should run the sample clock at even duty; others allowed.
// RULE5: Sleep request high selects standby; low selects normal conversion.
// RULE6: An undriven sleep request reads low, so the device converts.
// RULE7: Reference select low enables the on-chip bandgap and amplifier.
// RULE8: Reference select high disables on-chip reference; pin is an input.
// RULE9: Primary output is code over full scale; complement is the rest.
// RULE10: Between falling edges the output holds the last transferred word.
`ifndef DILC_REGS_SVH
`define DILC_REGS_SVH
`define DILC_DATA_WIDTH 12
`define DILC_FIFO_DEPTH 8
`define DILC_SLAVE_RESET 12'h000
`define DILC_FULL_SCALE 12'hFFF
`endif

// >>> hw/dilc_pkg.sv
`default_nettype none
package dilc_pkg;
	typedef enum logic [1:0] {
		DILC_REF_INTERNAL = 2'h1,
		DILC_REF_EXTERNAL = 2'h2
	} dilc_ref_mode_t;
endpackage : dilc_pkg
`default_nettype wire

// >>> sim/dilc_sample_source.sv
`default_nettype none
// ****************************************************************
// Sample source standing in for the synthesizer logic.
// ****************************************************************
module dilc_sample_source (
	input wire logic clk_in,
	input wire logic run_in,
	input wire logic ready_in,
	input wire logic ce_in,
	output logic [11:0] data_out,
	output logic valid_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic taken;
	logic go;
	initial begin
		data_out = 12'h000;
		valid_out = 1'b0;
		taken = 1'b0;
	end
	always @(posedge clk_in) taken = valid_out & ready_in & ce_in;
	// A word is held until it is taken; idle data toggles every cycle.
	always @(negedge clk_in) begin
		if (!valid_out || taken) begin
			go = run_in && ($urandom % 4 != 0);
			valid_out <= go;
			case ($urandom % 4)
				0: data_out <= go ? 12'h000 : ~data_out;
				1: data_out <= go ? 12'hFFF : ~data_out;
				default: data_out <= go ? 12'($urandom) : ~data_out;
			endcase
		end
	end
endmodule : dilc_sample_source
`default_nettype wire

// >>> sim/dilc_top_tb_top.sv
`default_nettype none
module dilc_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst = 1'b1, ce = 1'b1, run = 1'b0;
	logic sleep = 1'b0, driven = 1'b0, sel = 1'b0, valid, ready, ce_r;
	logic [11:0] data, code, comp, last = 12'h000, exp;
	logic [1:0] hist = 2'b00;
	logic [1:0] mode;
	logic stby, bg, pin_in;
	logic [11:0] exp_q[$];
	int errors = 0, num_checks = 0, cycles = 0;
	initial forever #5 clk = ~clk;
	dilc_sample_source src (.clk_in(clk), .run_in(run), .ready_in(ready),
		.ce_in(ce), .data_out(data), .valid_out(valid));
	dilc_top dut (.ref_clk_in(clk), .rst_in(rst), .ce_in(ce),
		.sample_data_in(data), .sample_valid_in(valid),
		.sample_ready_out(ready), .sleep_request_in(sleep),
		.sleep_request_driven_in(driven), .ref_select_in(sel),
		.code_out(code), .code_comp_out(comp), .standby_out(stby),
		.bandgap_enable_out(bg), .ref_mode_out(mode),
		.reference_voltage_pin_is_input_out(pin_in));
	task automatic check(input logic [11:0] got, input logic [11:0] want);
		num_checks++;
		if (got !== want) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, want);
		end
	endtask : check
	task automatic results;
		if (errors == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : results
	// ****************************************************************
	// Monitor: notes pushes, compares the word after the falling edge.
	// ****************************************************************
	always @(posedge clk) begin
		ce_r = ce;
		if (!rst && ce) begin
			hist = {hist[0], valid & ready};
			if (valid & ready) exp_q.push_back(data);
		end
		#1 if (!rst) check(code, last);
		if (++cycles == 3000) begin
			errors++;
			results();
		end
	end
	always @(negedge clk) begin
		#1 last = code;
		if (ce_r && hist[1] && exp_q.size() > 0) begin
			exp = exp_q.pop_front();
			check(code, exp);
			check(comp, 12'hFFF - exp);
		end
	end
	// ****************************************************************
	// Main sequence.
	// ****************************************************************
	initial begin
		void'($urandom(16893));
		repeat (11) @(negedge clk);
		#2 check(comp, 12'hFFF);
		check(code, 12'h000);
		check({6'h00, ready, stby, bg, pin_in, mode},
			{6'h00, 1'b0, 1'b0, 1'b1, 1'b0, 2'h1});
		@(negedge clk) rst <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			@(negedge clk) {sleep, driven, sel} <= 3'(i);
			@(negedge clk) #2;
			check({6'h00, ready, stby, bg, pin_in, mode},
				{6'h00, 1'b1, sleep & driven, !sel, sel,
				sel ? 2'h2 : 2'h1});
		end
		@(negedge clk) run <= 1'b1;
		repeat (600) @(negedge clk) ce <= ($urandom % 8 != 0);
		@(negedge clk) run <= 1'b0;
		ce <= 1'b1;
		repeat (6) @(negedge clk);
		check(12'(exp_q.size()), 12'h000);
		results();
	end
endmodule : dilc_top_tb_top
`default_nettype wire
